// ==== rtl/cfm_fault_monitor.sv ====
`timescale 1ns/1ps
module cfm_fault_monitor #(
  parameter int TICK_DIV = cfm_pkg::CFM_US_CYC,
  parameter int OV_REARM_US = cfm_pkg::CFM_OV_REARM_US,
  parameter int PG_DELAY_US = cfm_pkg::CFM_PG_DELAY_US,
  parameter int QUAL_SAMPLES = cfm_pkg::CFM_QUAL_SAMPLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [cfm_pkg::CFM_ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cfm_pkg::CFM_DATA_W-1:0] pwdata,
  output logic pready,
  output logic [cfm_pkg::CFM_DATA_W-1:0] prdata,
  output logic pslverr,
  // current monitors, millivolts
  input wire logic [cfm_pkg::CFM_MON_W-1:0] current_monitor_one,
  input wire logic [cfm_pkg::CFM_MON_W-1:0] current_monitor_two,
  // feedback comparators and converter state
  input wire logic fb_over_ov,
  input wire logic fb_in_pg_window,
  input wire logic fb_in_hold_window,
  input wire logic switch_tick,
  input wire logic slewing,
  input wire logic soft_start_done,
  input wire logic conv_enable,
  input wire logic over_temp,
  // monitoring converter
  input wire logic adc_done,
  input wire logic [cfm_pkg::CFM_ADC_W-1:0] adc_code,
  output logic adc_start,
  output cfm_pkg::cfm_adc_src_e adc_select,
  // power stage commands
  output cfm_pkg::cfm_drive_s drive,
  // pins
  output logic overcurrent_flag_out,
  output logic power_good_state,
  output logic bulk_cap_gate,
  output logic aux_switch_drive_out,
  output logic aux_switch_drive_oe_n,
  output logic int_out,
  output logic int_oe_n
);
  import cfm_pkg::*;

  typedef enum logic [1:0] {CFM_ADC_IDLE, CFM_ADC_START, CFM_ADC_WAIT} cfm_adc_state_e;
  localparam int TB_W = $clog2(TICK_DIV);

  // ----------------------------------------
  // microsecond timebase
  // ----------------------------------------
  logic [TB_W-1:0] tb_cnt;
  logic [TB_W-1:0] next_tb_cnt;
  logic us_tick;
  logic next_us_tick;

  always_comb begin
    next_us_tick = (tb_cnt == TB_W'(TICK_DIV - 1)); // R27
    next_tb_cnt = next_us_tick ? '0 : tb_cnt + TB_W'(1);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tb_cnt <= '0;
      us_tick <= 1'b0;
    end else begin
      tb_cnt <= next_tb_cnt;
      us_tick <= next_us_tick;
    end
  end

  // ----------------------------------------
  // apb registers
  // ----------------------------------------
  cfm_ctrl_s ctrl;
  cfm_ctrl_s next_ctrl;
  cfm_adc_ctrl_s adc_ctrl;
  cfm_adc_ctrl_s next_adc_ctrl;
  logic next_pready;
  logic next_pslverr;
  logic [CFM_DATA_W-1:0] next_prdata;
  logic [CFM_DATA_W-1:0] status_word;
  logic [CFM_DATA_W-1:0] adc_word;
  logic apb_done;
  logic wr_ctrl;
  logic wr_adc;
  logic wr_status;
  // fault and converter state read back through the bus
  logic ov_fault;
  logic temp_rec;
  logic ocp_rec;
  logic hot;
  logic rearm_done;
  logic [CFM_ADC_W-1:0] adc_data;
  logic adc_valid;
  cfm_adc_state_e adc_state;

  assign apb_done = psel & penable & pready;
  assign wr_ctrl = apb_done & pwrite & (paddr == CFM_CTRL_ADDR);
  assign wr_adc = apb_done & pwrite & (paddr == CFM_ADC_CTRL_ADDR);
  assign wr_status = apb_done & pwrite & (paddr == CFM_STATUS_ADDR);

  always_comb begin
    status_word = '0;
    status_word[CFM_ST_OV] = ov_fault;
    status_word[CFM_ST_PG] = power_good_state;
    status_word[CFM_ST_TEMP] = temp_rec;
    status_word[CFM_ST_OCP] = ocp_rec;
    status_word[CFM_ST_SUSP] = drive.suspend;
    status_word[CFM_ST_ARMED] = rearm_done;
    status_word[CFM_ST_BUSY] = (adc_state != CFM_ADC_IDLE);
    status_word[CFM_ST_HOT] = hot;
    adc_word = '0;
    adc_word[CFM_ADC_W-1:0] = adc_data;
    adc_word[CFM_AD_VALID] = adc_valid;
    // code scaled to millivolts at the multiplexer
    adc_word[CFM_AD_MV_LSB +: CFM_MV_W] = CFM_MV_W'(adc_data * CFM_ADC_STEP_MV); // R22
  end

  // one wait state: pready rises in the second access cycle
  always_comb begin
    next_pready = psel & penable & ~pready;
    next_prdata = prdata;
    next_pslverr = 1'b0;
    if (psel & penable & ~pready) begin
      next_prdata = '0;
      unique case (paddr)
        CFM_CTRL_ADDR: next_prdata = CFM_DATA_W'(ctrl);
        CFM_ADC_CTRL_ADDR: next_prdata = CFM_DATA_W'(adc_ctrl);
        CFM_STATUS_ADDR: next_prdata = status_word;
        CFM_ADC_DATA_ADDR: next_prdata = adc_word;
        default: next_pslverr = 1'b1;
      endcase
    end
  end

  always_comb begin
    next_ctrl = ctrl;
    next_adc_ctrl = adc_ctrl;
    if (wr_ctrl) begin
      next_ctrl = cfm_ctrl_s'(pwdata[CFM_CTRL_W-1:0]); // R1
    end
    if (wr_adc) begin
      next_adc_ctrl = cfm_adc_ctrl_s'(pwdata[CFM_ADC_CTRL_W-1:0]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CFM_CTRL_RST; // R2
      adc_ctrl <= CFM_ADC_CTRL_RST;
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      adc_ctrl <= next_adc_ctrl;
      pready <= next_pready;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // ----------------------------------------
  // qualifiers and timers
  // ----------------------------------------
  logic ov_tripped;
  logic pg_lost;
  logic pg_done;

  cfm_window_qual #(.SAMPLES(QUAL_SAMPLES)) u_ov_qual (
    .pclk(pclk),
    .presetn(presetn),
    .sample_tick(switch_tick),
    .outside(fb_over_ov),
    .tripped(ov_tripped)
  );

  cfm_window_qual #(.SAMPLES(QUAL_SAMPLES)) u_pg_qual (
    .pclk(pclk),
    .presetn(presetn),
    .sample_tick(switch_tick),
    .outside(~fb_in_hold_window),
    .tripped(pg_lost)
  );

  // a slew or an unfinished soft start resets the re-arm delay
  cfm_qual_timer #(.LEN(OV_REARM_US)) u_ov_rearm (
    .pclk(pclk),
    .presetn(presetn),
    .tick(us_tick),
    .run(conv_enable & soft_start_done & ~slewing),
    .done(rearm_done)
  );

  cfm_qual_timer #(.LEN(PG_DELAY_US)) u_pg_timer (
    .pclk(pclk),
    .presetn(presetn),
    .tick(us_tick),
    .run(conv_enable & fb_in_pg_window),
    .done(pg_done)
  );

  // ----------------------------------------
  // fault handling
  // ----------------------------------------
  logic oc_trip;
  logic next_oc_flag;
  logic next_ov_fault;
  logic next_temp_rec;
  logic next_ocp_rec;
  logic next_hot;
  logic next_pg;
  logic next_int_act;
  cfm_drive_s next_drive;

  always_comb begin
    oc_trip = (current_monitor_one > cfm_limit_mv(ctrl.lim_one)) // R3
      | (current_monitor_two > cfm_limit_mv(ctrl.lim_two));
    next_oc_flag = oc_trip; // R3
    next_hot = over_temp;
    // sticky records: a new event wins over a write-one clear
    next_ocp_rec = (ocp_rec & ~(wr_status & pwdata[CFM_ST_OCP])) | oc_trip;
    next_temp_rec = (temp_rec & ~(wr_status & pwdata[CFM_ST_TEMP])) | over_temp; // R17
    next_ov_fault = rearm_done & ov_tripped & ~ctrl.overvoltage_mask; // R5 R8 R9 R11
    next_pg = power_good_state;
    if (!conv_enable || pg_lost) begin
      next_pg = 1'b0; // R13
    end else if (pg_done) begin
      next_pg = 1'b1; // R12
    end
    next_drive.all_off = over_temp; // R16
    next_drive.ov_discharge = next_ov_fault & ~over_temp; // R6
    next_drive.freq_50k = next_ov_fault; // R7
    // cooling down leads to a discharge, not back to regulation
    next_drive.safe_discharge = conv_enable & ~over_temp
      & (drive.safe_discharge | hot); // R18
    next_drive.suspend = conv_enable & (drive.suspend | (oc_trip & ctrl.ocp_latch)); // R4
    next_int_act = (ov_fault & ~ctrl.overvoltage_mask) // R11 R26
      | (temp_rec & ~ctrl.temp_mask) // R17 R26
      | (ctrl.int_shows_pg & ~ctrl.power_good_mask & ~power_good_state); // R14 R15
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overcurrent_flag_out <= 1'b0;
      ov_fault <= 1'b0;
      temp_rec <= 1'b0;
      ocp_rec <= 1'b0;
      hot <= 1'b0;
      power_good_state <= 1'b0;
      drive <= '0;
      int_oe_n <= 1'b1;
      int_out <= 1'b0;
      bulk_cap_gate <= 1'b0;
      aux_switch_drive_oe_n <= 1'b1;
      aux_switch_drive_out <= 1'b0;
    end else begin
      overcurrent_flag_out <= next_oc_flag;
      ov_fault <= next_ov_fault;
      temp_rec <= next_temp_rec;
      ocp_rec <= next_ocp_rec;
      hot <= next_hot;
      power_good_state <= next_pg;
      drive <= next_drive;
      int_oe_n <= ~next_int_act; // R26
      int_out <= 1'b0;
      bulk_cap_gate <= ctrl.bulk_cap_gate_ctrl; // R19
      aux_switch_drive_oe_n <= ~ctrl.aux_switch_drive; // R20
      aux_switch_drive_out <= 1'b0;
    end
  end

  // ----------------------------------------
  // monitoring converter sequencing
  // ----------------------------------------
  cfm_adc_state_e next_adc_state;
  logic req_pend;
  logic next_req_pend;
  logic fault_prev;
  logic fault_rise;
  logic start_now;
  logic next_adc_start;
  cfm_adc_src_e next_adc_select;
  logic [CFM_ADC_W-1:0] next_adc_data;
  logic next_adc_valid;

  // a fault seen while converting is queued, not dropped
  always_comb begin
    fault_rise = (ov_fault | hot | overcurrent_flag_out) & ~fault_prev;
    start_now = 1'b0;
    next_adc_state = adc_state;
    next_adc_start = 1'b0;
    next_adc_select = adc_select;
    next_adc_data = adc_data;
    next_adc_valid = adc_valid;
    unique case (adc_state)
      CFM_ADC_IDLE: begin
        if (req_pend || adc_ctrl.trig == CFM_TRIG_CONT) begin
          start_now = 1'b1;
          next_adc_state = CFM_ADC_START;
          next_adc_start = 1'b1;
          next_adc_select = adc_ctrl.src; // R21 R24
        end
      end
      CFM_ADC_START: next_adc_state = CFM_ADC_WAIT;
      CFM_ADC_WAIT: begin
        if (adc_done) begin
          next_adc_data = adc_code; // R21
          next_adc_valid = 1'b1;
          next_adc_state = CFM_ADC_IDLE;
        end
      end
    endcase
    next_req_pend = req_pend & ~start_now;
    unique case (adc_ctrl.trig)
      CFM_TRIG_FAULT: next_req_pend = next_req_pend | fault_rise; // R25
      CFM_TRIG_ONCE: next_req_pend = next_req_pend | (wr_adc & ~start_now); // R25
      CFM_TRIG_CONT: next_req_pend = 1'b0; // R25
      default: next_req_pend = 1'b0;
    endcase
    // a write that selects a single sample arms exactly one
    if (wr_adc && pwdata[CFM_ADC_CTRL_W-1 -: 2] == CFM_TRIG_ONCE) begin
      next_req_pend = 1'b1; // R25
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_state <= CFM_ADC_IDLE;
      req_pend <= 1'b0;
      fault_prev <= 1'b0;
      adc_start <= 1'b0;
      adc_select <= CFM_SRC_FB;
      adc_data <= '0;
      adc_valid <= 1'b0;
    end else begin
      adc_state <= next_adc_state;
      req_pend <= next_req_pend;
      fault_prev <= ov_fault | hot | overcurrent_flag_out;
      adc_start <= next_adc_start;
      adc_select <= next_adc_select;
      adc_data <= next_adc_data;
      adc_valid <= next_adc_valid;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_oc_flag_follow: assert property ( // R3
    (current_monitor_one > cfm_limit_mv(ctrl.lim_one)) |=> overcurrent_flag_out)
    else $error("overcurrent flag missed a monitor one trip");
  a_ocp_suspend_hold: assert property ( // R4
    drive.suspend && conv_enable |=> drive.suspend)
    else $error("suspend released while converter still enabled");
  a_ov_fault_slow: assert property ( // R7
    ov_fault |-> drive.freq_50k && !ctrl.overvoltage_mask || $past(!ctrl.overvoltage_mask))
    else $error("over-voltage fault without slow switching");
  a_ov_slew_block: assert property ( // R8
    slewing |=> !rearm_done ##1 !ov_fault)
    else $error("over-voltage detection active during slew");
  a_ov_mask_both: assert property ( // R11
    ctrl.overvoltage_mask [*2] |-> !ov_fault && !drive.freq_50k)
    else $error("masked over-voltage still acting");
  a_pg_needs_timer: assert property ( // R12
    $rose(power_good_state) |-> $past(pg_done) && $past(fb_in_pg_window, 2))
    else $error("power good rose without the qualification delay");
  a_temp_all_off: assert property ( // R16
    over_temp |=> drive.all_off && !drive.ov_discharge)
    else $error("switches not parked during over-temperature");
  a_int_pg_start: assert property ( // R14
    ctrl.int_shows_pg && !ctrl.power_good_mask && !power_good_state |=> !int_oe_n)
    else $error("interrupt pin not showing missing power good");
  a_aux_drive: assert property ( // R20
    ctrl.aux_switch_drive |=> !aux_switch_drive_oe_n && !aux_switch_drive_out)
    else $error("auxiliary pulldown not enabled");
  a_apb_wait_one: assert property (
    psel && penable && !pready |=> pready)
    else $error("bus answer took more than one wait state");
endmodule : cfm_fault_monitor

// ==== rtl/cfm_pkg.sv ====
// Operation
// R1: each monitor limit code picks 0.25, 0.75, 1.5 or 2.5 V
// R2: both monitor limits reset to the lowest setting, 250 mV
// R3: overcurrent flag is high while either monitor exceeds its own limit
// R4: a configuration bit selects suspend-until-restart or flag-only on a trip
// R5: over-voltage fault needs feedback above 120% for over one switching cycle
// R6: during over-voltage the buck side is parked and boost side discharges
// R7: during over-voltage the converter switches at 50 kHz
// R8: over-voltage detection is suppressed while the output is slewing
// R9: over-voltage detection re-arms 1 ms after soft start completes
// R10: host avoids targets below 100 mV and disables instead of zero
// R11: over-voltage mask set hides both the action and the indication
// R12: power good rises only after 3.3 ms inside the 5% window
// R13: power good clears after over one cycle outside the 7.5% window
// R14: interrupt pin can show power-good state, active until good at startup
// R15: power-good mask set hides both the action and the indication; the code masks only the interrupt term, power_good_state is unaffected
// R16: over-temperature turns all four switches off until it clears
// R17: thermal fault is recorded and raises interrupt unless masked
// R18: when over-temperature clears the output is discharged to zero volts
// R19: one control bit engages the bulk capacitor gate, reset disengaged
// R20: one control bit turns on the auxiliary open-drain pulldown, reset off
// R21: converter digitises feedback, input rail or either monitor to 7 bits
// R22: each converter code step is 20 mV at the multiplexer
// R23: host sets trigger mode before enabling, writing zero before a change
// R24: source code 00 feedback, 01 input rail, 10 monitor two, 11 monitor one
// R25: trigger code 00 sample on fault, 01 sample once, 10 continuous
// R26: masked sources never assert the interrupt pin, unmasked ones do
// R27: millisecond timers run from a fixed timebase and restart when lost
// R28: window qualifications need two consecutive out-of-window period samples
package cfm_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam int CFM_ADDR_W = 8;
  localparam int CFM_DATA_W = 32;
  localparam logic [7:0] CFM_CTRL_ADDR = 8'h00;
  localparam logic [7:0] CFM_ADC_CTRL_ADDR = 8'h04;
  localparam logic [7:0] CFM_STATUS_ADDR = 8'h08;
  localparam logic [7:0] CFM_ADC_DATA_ADDR = 8'h0C;
  // status bit positions
  localparam int CFM_ST_OV = 0;
  localparam int CFM_ST_PG = 1;
  localparam int CFM_ST_TEMP = 2;
  localparam int CFM_ST_OCP = 3;
  localparam int CFM_ST_SUSP = 4;
  localparam int CFM_ST_ARMED = 5;
  localparam int CFM_ST_BUSY = 6;
  localparam int CFM_ST_HOT = 7;
  // converter data fields
  localparam int CFM_AD_VALID = 7;
  localparam int CFM_AD_MV_LSB = 16;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CFM_CLK_HZ = 40_000_000;
  localparam int CFM_US_CYC = CFM_CLK_HZ / 1_000_000;
  localparam int CFM_OV_REARM_US = 1000;
  localparam int CFM_PG_DELAY_US = 3300;
  localparam int CFM_QUAL_SAMPLES = 2;
  // ----------------------------------------
  // analog scaling
  // ----------------------------------------
  localparam int CFM_MON_W = 12;
  localparam int CFM_ADC_W = 7;
  localparam int CFM_MV_W = 12;
  localparam logic [11:0] CFM_ADC_STEP_MV = 12'h014;
  localparam logic [11:0] CFM_LIM_250_MV = 12'h0FA;
  localparam logic [11:0] CFM_LIM_750_MV = 12'h2EE;
  localparam logic [11:0] CFM_LIM_1500_MV = 12'h5DC;
  localparam logic [11:0] CFM_LIM_2500_MV = 12'h9C4;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {CFM_LIM_250, CFM_LIM_750, CFM_LIM_1500, CFM_LIM_2500} cfm_lim_e;
  typedef enum logic [1:0] {CFM_SRC_FB, CFM_SRC_RAIL, CFM_SRC_MON_TWO, CFM_SRC_MON_ONE} cfm_adc_src_e;
  typedef enum logic [1:0] {CFM_TRIG_FAULT, CFM_TRIG_ONCE, CFM_TRIG_CONT} cfm_trig_e;
  typedef struct packed {
    logic aux_switch_drive;
    logic bulk_cap_gate_ctrl;
    logic int_shows_pg;
    logic temp_mask;
    logic power_good_mask;
    logic overvoltage_mask;
    logic ocp_latch;
    cfm_lim_e lim_two;
    cfm_lim_e lim_one;
  } cfm_ctrl_s;
  typedef struct packed {
    cfm_trig_e trig;
    cfm_adc_src_e src;
  } cfm_adc_ctrl_s;
  typedef struct packed {
    logic suspend;
    logic safe_discharge;
    logic freq_50k;
    logic ov_discharge;
    logic all_off;
  } cfm_drive_s;
  localparam int CFM_CTRL_W = $bits(cfm_ctrl_s);
  localparam int CFM_ADC_CTRL_W = $bits(cfm_adc_ctrl_s);
  // lowest limits, everything off
  localparam cfm_ctrl_s CFM_CTRL_RST = '0;
  localparam cfm_adc_ctrl_s CFM_ADC_CTRL_RST = '0;

  function automatic logic [11:0] cfm_limit_mv(input cfm_lim_e sel);
    logic [11:0] mv;
    unique case (sel)
      CFM_LIM_250: mv = CFM_LIM_250_MV;
      CFM_LIM_750: mv = CFM_LIM_750_MV;
      CFM_LIM_1500: mv = CFM_LIM_1500_MV;
      CFM_LIM_2500: mv = CFM_LIM_2500_MV;
    endcase
    return mv;
  endfunction : cfm_limit_mv
endpackage : cfm_pkg

// ==== rtl/cfm_window_qual.sv ====
`timescale 1ns/1ps
module cfm_window_qual #(
  parameter int SAMPLES = 2
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // sampling
  input wire logic sample_tick,
  input wire logic outside,
  // result
  output logic tripped
);
  import cfm_pkg::*;
  localparam int CW = $clog2(SAMPLES + 1);
  logic [CW-1:0] run_cnt;
  logic [CW-1:0] next_run_cnt;
  logic next_tripped;

  // one sample per switching period, so a single glitchy period never trips
  always_comb begin
    next_run_cnt = run_cnt;
    next_tripped = tripped;
    if (sample_tick) begin
      if (!outside) begin
        next_run_cnt = '0;
        next_tripped = 1'b0;
      end else if (!tripped) begin
        next_run_cnt = run_cnt + CW'(1);
        next_tripped = (run_cnt == CW'(SAMPLES - 1)); // R28
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_cnt <= '0;
      tripped <= 1'b0;
    end else begin
      run_cnt <= next_run_cnt;
      tripped <= next_tripped;
    end
  end
endmodule : cfm_window_qual

// ==== rtl/cfm_qual_timer.sv ====
`timescale 1ns/1ps
module cfm_qual_timer #(
  parameter int LEN = 1000
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // timebase and condition
  input wire logic tick,
  input wire logic run,
  // result
  output logic done
);
  import cfm_pkg::*;
  localparam int CW = $clog2(LEN + 1);
  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic next_done;

  always_comb begin
    next_cnt = cnt;
    next_done = done;
    if (!run) begin
      next_cnt = '0; // R27
      next_done = 1'b0;
    end else if (tick && !done) begin
      next_cnt = cnt + CW'(1);
      next_done = (cnt == CW'(LEN - 1)); // R27
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
      done <= 1'b0;
    end else begin
      cnt <= next_cnt;
      done <= next_done;
    end
  end
endmodule : cfm_qual_timer

// ==== test/cfm_host_model.sv ====
`timescale 1ns/1ps
module cfm_host_model (
  // clock
  input wire logic pclk,
  // apb master
  output logic [cfm_pkg::CFM_ADDR_W-1:0] paddr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [cfm_pkg::CFM_DATA_W-1:0] pwdata,
  input wire logic pready,
  input wire logic [cfm_pkg::CFM_DATA_W-1:0] prdata,
  input wire logic pslverr
);
  import cfm_pkg::*;
  // this host never programs an output target, so no low target is written
  initial begin
    {psel, penable, pwrite} = 3'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // one transfer; returns at the edge where pready is seen
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released data must not keep looking valid
    pwdata <= ~d;
  endtask : xfer
endmodule : cfm_host_model

// ==== test/cfm_fault_monitor_tb_top.sv ====
`timescale 1ns/1ps
module cfm_fault_monitor_tb_top;
  import cfm_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0;
  logic [7:0] paddr;
  logic psel, penable, pwrite, pready, pslverr;
  logic [31:0] pwdata, prdata, rd;
  logic [11:0] current_monitor_one = 12'h0, current_monitor_two = 12'h0;
  logic fb_over_ov = 0, fb_in_pg_window = 0, fb_in_hold_window = 0, switch_tick = 0;
  logic slewing = 0, soft_start_done = 0, conv_enable = 0, over_temp = 0;
  logic adc_done = 0, adc_start, overcurrent_flag_out, power_good_state, bulk_cap_gate;
  logic [6:0] adc_code = 7'h05;
  logic aux_switch_drive_out, aux_switch_drive_oe_n, int_out, int_oe_n, er;
  logic [2:0] tcnt = 3'h0;
  cfm_adc_src_e adc_select;
  cfm_drive_s drive;
  int error_cnt = 0, n_tests = 0, i;
  // rows: limit code, monitor millivolts, expected flag
  logic [14:0] rows [8] = '{{2'h0, 12'h0FA, 1'b0}, {2'h0, 12'h0FB, 1'b1}, {2'h1, 12'h2EE, 1'b0},
    {2'h1, 12'h2EF, 1'b1}, {2'h2, 12'h5DC, 1'b0}, {2'h2, 12'h5DD, 1'b1}, {2'h3, 12'h9C4, 1'b0},
    {2'h3, 12'h9C5, 1'b1}};
  always #12.5 pclk = ~pclk;
  // converter stand-in: every start is answered one cycle later, so fault-triggered samples never hang
  always @(posedge pclk) adc_done <= adc_start;
  // switching period of eight clocks
  always @(posedge pclk) begin
    tcnt <= tcnt + 3'h1;
    switch_tick <= (tcnt == 3'h7);
  end
  cfm_host_model i_host (.pclk, .paddr, .psel, .penable, .pwrite, .pwdata, .pready, .prdata, .pslverr);
  cfm_fault_monitor #(.TICK_DIV(2), .OV_REARM_US(5), .PG_DELAY_US(8), .QUAL_SAMPLES(2)) i_dut (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pready, .prdata, .pslverr,
    .current_monitor_one, .current_monitor_two, .fb_over_ov, .fb_in_pg_window, .fb_in_hold_window,
    .switch_tick, .slewing, .soft_start_done, .conv_enable, .over_temp, .adc_done, .adc_code,
    .adc_start, .adc_select, .drive, .overcurrent_flag_out, .power_good_state, .bulk_cap_gate,
    .aux_switch_drive_out, .aux_switch_drive_oe_n, .int_out, .int_oe_n);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask : wt
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_host.xfer(1'b1, a, d, rd, er);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    i_host.xfer(1'b0, a, 32'h0, rd, er);
    chk(rd, exp);
  endtask : rdc
  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    end_of_test;
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rdc(CFM_CTRL_ADDR, 32'h0);
    chk({bulk_cap_gate, aux_switch_drive_oe_n, int_oe_n}, 3'h3);
    rdc(8'h10, 32'h0);
    chk(er, 1'b1);
    wr(CFM_CTRL_ADDR, 32'h600);
    wt(2);
    chk({bulk_cap_gate, aux_switch_drive_oe_n}, 2'h2);
    for (int j = 0; j < 2; j++) begin
      for (int k = 0; k < 8; k++) begin
        wr(CFM_CTRL_ADDR, j ? {rows[k][14:13], 2'h3} : {2'h3, rows[k][14:13]});
        current_monitor_one <= j ? 12'h0 : rows[k][12:1];
        current_monitor_two <= j ? rows[k][12:1] : 12'h0;
        wt(3);
        chk(overcurrent_flag_out, rows[k][0]);
      end
    end
    current_monitor_two <= 12'h0;
    wr(CFM_ADC_CTRL_ADDR, 32'h0);
    wr(CFM_ADC_CTRL_ADDR, 32'h5);
    i = 0;
    while (adc_start !== 1'b1 && i < 10) begin
      @(posedge pclk);
      i++;
    end
    chk({adc_start, adc_select}, {1'b1, CFM_SRC_RAIL});
    rdc(CFM_ADC_DATA_ADDR, 32'h0064_0085);
    {over_temp, conv_enable} <= 2'h3;
    wt(2);
    chk(drive.all_off, 1'b1);
    wt(1);
    chk(int_oe_n, 1'b0);
    rdc(CFM_STATUS_ADDR, 32'h8C);
    over_temp <= 1'b0;
    wt(2);
    chk({drive.safe_discharge, drive.all_off}, 2'h2);
    wr(CFM_CTRL_ADDR, 32'h80);
    wr(CFM_STATUS_ADDR, 32'hC);
    over_temp <= 1'b1;
    wt(4);
    chk(int_oe_n, 1'b1);
    over_temp <= 1'b0;
    {conv_enable, soft_start_done} <= 2'h3;
    wt(4);
    rdc(CFM_STATUS_ADDR, 32'h4);
    wt(20);
    rdc(CFM_STATUS_ADDR, 32'h24);
    fb_over_ov <= 1'b1;
    wt(30);
    chk({drive.freq_50k, drive.ov_discharge}, 2'h3);
    // over-voltage input stays high: only the slew may take the fault away
    slewing <= 1'b1;
    wt(3);
    chk(drive.freq_50k, 1'b0);
    rdc(CFM_STATUS_ADDR, 32'h4);
    {fb_over_ov, fb_in_pg_window, fb_in_hold_window, slewing} <= 4'h6;
    wt(8);
    chk(power_good_state, 1'b0);
    wt(30);
    chk(power_good_state, 1'b1);
    {fb_in_pg_window, fb_in_hold_window} <= 2'h0;
    wt(26);
    chk(power_good_state, 1'b0);
    wr(CFM_CTRL_ADDR, 32'h130);
    current_monitor_one <= 12'h0FB;
    wt(3);
    chk(drive.suspend, 1'b1);
    current_monitor_one <= 12'h0;
    wt(3);
    chk(drive.suspend, 1'b1);
    conv_enable <= 1'b0;
    wt(2);
    chk({drive.suspend, drive.safe_discharge, int_out, aux_switch_drive_out}, 4'h0);
    wr(CFM_ADC_CTRL_ADDR, 32'h0);
    wr(CFM_ADC_CTRL_ADDR, 32'h8);
    i = 0;
    repeat (12) begin
      @(posedge pclk);
      i += adc_start;
    end
    chk(i > 1, 1'b1);
    end_of_test;
  end
endmodule : cfm_fault_monitor_tb_top
